//--- rscm_pkg.sv
// constants, types and config carrier for the rail sync/current manager
package rscm_pkg;
  // clock and sampling timing
  localparam int CLK_MHZ = 100; // device clock rate
  localparam int SLOT_US = 200; // one rail measured per slot
  localparam int TAU_X10 = 35; // filter tau in tenths of a slot
  // filter weight in 1/256 units, 256/3.5
  localparam logic [9:0] FILT_K = 10'(2560 / TAU_X10);
  // calibration gain fraction bits (gain 16'h1000 = 1.0)
  localparam int CAL_FRAC = 12;
  // sync routing word layout and reset
  localparam int SYNC_OUT_LSB = 8;
  localparam logic [7:0] SYNC_SEL_MAX = 8'h03; // 0..3 pick a stage
  localparam logic [15:0] SYNC_WORD_RST = 16'hff00;
  // rail-to-rail spread ratio
  localparam logic [17:0] SPREAD_NUM = 18'h00003;
  localparam logic [17:0] SPREAD_DEN = 18'h0000d;
  // balance adjustment
  localparam logic [11:0] BAL_INIT = 12'h800;
  localparam logic [11:0] BAL_STEP = 12'h001;
  localparam logic [11:0] BAL_MAX = 12'hffe;
  // stage positions
  localparam logic [1:0] STG_1A = 2'h0;
  localparam logic [1:0] STG_3A = 2'h3;
  // sampler states
  typedef enum logic [1:0] {
    SM_IDLE = 2'b00,
    SM_SEL = 2'b01,
    SM_WAIT = 2'b10,
    SM_EVAL = 2'b11
  } rscm_state_t;
  // rail configuration carrier
  typedef struct packed {
    logic [2:0] n_r1;
    logic [1:0] n_r2;
    logic [15:0] per1;
    logic [15:0] per2;
    logic shed_en;
    logic [1:0] shed_n;
    logic light_coef_en;
    logic [15:0] ll_low;
    logic [15:0] ll_high;
    logic [15:0] oc_fault;
    logic [15:0] oc_warn;
    logic [15:0] uc_warn;
    logic [15:0] uc_fault;
  } rscm_cfg_t;
  // per-rail current flags
  typedef struct packed {
    logic oc_fault;
    logic oc_warn;
    logic uc_warn;
    logic uc_fault;
  } rscm_flags_t;
endpackage

//--- rscm_top.sv
// rail sync, phase shedding, current sampling and balancing logic
`timescale 1ns/100ps
// Overview of operation
// - followed rail ramp timers reset on sync rise
// - sync at any faster rate locks period
// - upper byte picks sync output stage, else off
// - lower byte masks rails that follow sync
// - external sync kills rail spread until restart
// - light load sheds configured stage count when the rail has more stages than that
// - light coefficient set used on light load
// - above restore level, re-enable all, normal coefs
// - samples scaled by stage gain and offset
// - beyond fault threshold declares current fault
// - averaged current compared with thresholds
// - one rail per 200 us slot
// - exponential smoothing, tau 3.5 slots
// - reads return averaged rail sum
// - one shared 12-bit ADC, round robin
// - A channel comparator, zero level disables
// - per-stage balance added to ramp threshold
// - lowest raised as much as highest lowered
// - balance values always stay positive
// - second rail offset 3/13 of fastest period
// - stages spaced by period over active count
// - bank two coefficients while below light level
module rscm_top
  import rscm_pkg::*;
#(
  parameter int SLOT_CYC = SLOT_US * CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sync_in,
  input wire logic warm_restart,
  input wire rscm_cfg_t cfg,
  input wire logic sync_wr,
  input wire logic [15:0] sync_wdata,
  input wire logic [3:0][15:0] cal_gain,
  input wire logic [3:0][15:0] cal_ofs,
  input wire logic [2:0][5:0] trip_level,
  input wire logic [2:0] fast_cmp_hit,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  input wire logic rd_req,
  input wire logic rd_rail,
  output logic [15:0] sync_word_reg,
  output logic sync_out_reg,
  output logic [3:0][15:0] ramp_cnt_reg,
  output logic [3:0] ramp_start_reg,
  output logic phase_offset_en_reg,
  output logic [3:0] stage_en_reg,
  output logic [1:0] coef_light_reg,
  output logic [3:0][11:0] bal_adj_reg,
  output logic adc_start_reg,
  output logic [1:0] adc_chan_reg,
  output logic [2:0] cmp_en_reg,
  output logic [2:0] fast_trip_reg,
  output rscm_flags_t [1:0] flags_reg,
  output logic rd_valid_reg,
  output logic [17:0] rd_data_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // sign-extend a 16-bit threshold to sum width
  function automatic logic signed [17:0] sx(input logic [15:0] t);
    sx = $signed({{2{t[15]}}, t});
  endfunction

  // divide by active stage count 1..4
  function automatic logic [15:0] div_n(input logic [17:0] x,
                                        input logic [2:0] n);
    case (n)
      3'd2: div_n = x[16:1];
      3'd3: div_n = 16'(x / 18'd3);
      3'd4: div_n = x[17:2];
      default: div_n = x[15:0];
    endcase
  endfunction

  // pin synchronisers, stage one only feeds stage two
  logic [3:0] pin_s1_reg; // raw capture
  logic [3:0] pin_s2_reg; // safe copy
  logic sync_d_reg; // for edge detect
  logic sync_edge; // one cycle per sync rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      sync_d_reg <= 1'b0;
    end else if (ce) begin
      pin_s1_reg <= {fast_cmp_hit, sync_in};
      pin_s2_reg <= pin_s1_reg;
      sync_d_reg <= pin_s2_reg[0];
    end
  end
  assign sync_edge = pin_s2_reg[0] & ~sync_d_reg;

  // stage map and live registers shared by groups
  logic [3:0] used; // stage configured
  logic [3:0] in_r2; // stage belongs to rail two
  logic [3:0][1:0] idx; // position inside its rail
  logic [1:0][2:0] n_stg; // stages per rail
  logic [1:0][2:0] n_act; // stages left after shedding
  logic [1:0] light_reg; // rail in light-load state
  logic synced_reg; // a rail was externally synced
  logic restart_reg; // reload phases this cycle
  always_comb begin
    used[0] = cfg.n_r1 != 3'd0;
    used[1] = cfg.n_r1 >= 3'd2;
    used[2] = cfg.n_r2 != 2'd0 || cfg.n_r1 >= 3'd3;
    used[3] = cfg.n_r2 == 2'd2 || cfg.n_r1 == 3'd4 ||
              (cfg.n_r1 == 3'd3 && cfg.n_r2 == 2'd1);
    in_r2 = {cfg.n_r2 == 2'd2, cfg.n_r2 != 2'd0, 2'b00};
    idx[0] = 2'd0;
    idx[1] = 2'd1;
    idx[2] = in_r2[2] ? 2'd0 : 2'd2;
    idx[3] = in_r2[3] ? 2'd1 : (cfg.n_r2 == 2'd1 ? 2'd2 : 2'd3);
    n_stg[0] = cfg.n_r1;
    n_stg[1] = {1'b0, cfg.n_r2};
    for (int r = 0; r < 2; r++) begin
      // shed stages drop out of the phase spread
      if (light_reg[r] && n_stg[r] > {1'b0, cfg.shed_n})
        n_act[r] = n_stg[r] - {1'b0, cfg.shed_n};
      else
        n_act[r] = n_stg[r];
    end
  end

  // phase load values for restart and for sync edges
  logic [15:0] fast_per; // period of fastest rail
  logic [15:0] spread; // rail-to-rail offset
  logic spread_on; // spread allowed now
  logic [3:0][15:0] ld_rst; // counter load on restart
  logic [3:0][15:0] ld_syn; // counter load on sync edge
  always_comb begin
    logic [15:0] p;
    logic [15:0] off;
    logic [16:0] tot;
    p = 16'h0000;
    off = 16'h0000;
    tot = 17'h00000;
    fast_per = (cfg.per2 < cfg.per1) ? cfg.per2 : cfg.per1;
    spread = 16'(({2'b00, fast_per} * SPREAD_NUM) / SPREAD_DEN);
    spread_on = cfg.n_r2 != 2'd0 && !synced_reg &&
                sync_word_reg[7:0] == 8'h00;
    for (int i = 0; i < 4; i++) begin
      p = in_r2[i] ? cfg.per2 : cfg.per1;
      off = div_n(18'({2'b00, p} * 18'(idx[i])),
                  n_act[in_r2[i]]);
      ld_syn[i] = (off == 16'h0000) ? 16'h0000 : 16'(p - off);
      tot = {1'b0, off} + ((in_r2[i] && spread_on) ?
            {1'b0, spread} : 17'h00000);
      if (tot >= {1'b0, p})
        tot = tot - {1'b0, p};
      ld_rst[i] = (tot == 17'h00000) ? 16'h0000 : 16'(p - tot[15:0]);
    end
  end

  // ramp timers, sync routing and sync output
  logic [3:0][15:0] cnt_next;
  logic [3:0] start_next;
  logic sync_out_next;
  logic [15:0] sync_word_next;
  logic synced_next;
  always_comb begin
    logic [15:0] p;
    p = 16'h0000;
    sync_word_next = sync_wr ? sync_wdata : sync_word_reg;
    for (int i = 0; i < 4; i++) begin
      p = in_r2[i] ? cfg.per2 : cfg.per1;
      if (restart_reg)
        cnt_next[i] = ld_rst[i]; // power-up and warm restart spread
      else if (sync_edge && sync_word_reg[in_r2[i]])
        cnt_next[i] = ld_syn[i];
      else if (ramp_cnt_reg[i] >= 16'(p - 16'h0001))
        cnt_next[i] = 16'h0000; // period wrap
      else
        cnt_next[i] = ramp_cnt_reg[i] + 16'h0001;
      start_next[i] = used[i] && cnt_next[i] == 16'h0000;
    end
    // stage 0..3 selectable, any other value disables
    sync_out_next = sync_word_reg[15:SYNC_OUT_LSB] <= SYNC_SEL_MAX &&
                    start_next[sync_word_reg[SYNC_OUT_LSB+1:SYNC_OUT_LSB]];
    // a sync edge in the restart cycle still marks the rail synced
    if (sync_edge && sync_word_reg[1:0] != 2'b00)
      synced_next = 1'b1;
    else if (restart_reg)
      synced_next = 1'b0; // spread restored
    else
      synced_next = synced_reg;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_cnt_reg <= '0;
      ramp_start_reg <= 4'h0;
      sync_out_reg <= 1'b0;
      sync_word_reg <= SYNC_WORD_RST;
      synced_reg <= 1'b0;
      phase_offset_en_reg <= 1'b1;
      restart_reg <= 1'b1;
    end else if (ce) begin
      ramp_cnt_reg <= cnt_next;
      ramp_start_reg <= start_next;
      sync_out_reg <= sync_out_next;
      sync_word_reg <= sync_word_next;
      synced_reg <= synced_next;
      phase_offset_en_reg <= !synced_next;
      restart_reg <= warm_restart;
    end
  end
  sequence s_sync0;
    ce && sync_edge && sync_word_reg[0] && !restart_reg;
  endsequence
  sync_reset_a: assert property (s_sync0 |=>
    ramp_cnt_reg[0] == $past(ld_syn[0]))
    else $error("followed timer not reset on sync");
  sync_fast_a: assert property (s_sync0 ##1 (ce && !sync_edge)[*2]
    ##1 s_sync0 |=> ramp_cnt_reg[0] == $past(ld_syn[0]))
    else $error("fast sync not locked");
  sync_out_off_a: assert property (ce &&
    sync_word_reg[15:SYNC_OUT_LSB] > SYNC_SEL_MAX |=> !sync_out_reg)
    else $error("sync output not disabled");
  spread_lost_a: assert property (ce && sync_edge &&
    sync_word_reg[1:0] != 2'b00 |=> !phase_offset_en_reg)
    else $error("spread kept after sync");

  // current sampler, filter, faults, shedding, balance
  logic [1:0][17:0] sum; // averaged rail sums
  logic [17:0] rd_sum; // sum for selected read rail
  logic [3:0][15:0] avg_reg;
  logic [3:0][15:0] avg_next;
  rscm_state_t state_reg;
  rscm_state_t state_next;
  logic [15:0] tmr_reg; // slot timer
  logic [15:0] tmr_next;
  logic [1:0] st_reg; // stage being sampled
  logic [1:0] st_next;
  logic rail_reg; // rail of this slot
  logic rail_next;
  logic [1:0] light_next;
  logic adc_start_next;
  logic [1:0] adc_chan_next;
  logic [3:0] stage_en_next;
  logic [1:0] coef_light_next;
  logic [3:0][11:0] bal_next;
  rscm_flags_t [1:0] flags_next;
  logic [2:0] cmp_en_next;
  logic [2:0] fast_trip_next;
  always_comb begin
    logic [27:0] prod;
    logic [15:0] smp;
    logic signed [16:0] diff;
    logic signed [26:0] stp;
    logic signed [17:0] s;
    logic [1:0] hi;
    logic [1:0] lo;
    logic act;
    prod = 28'h0000000;
    smp = 16'h0000;
    diff = 17'sd0;
    stp = 27'sd0;
    s = 18'sd0;
    hi = 2'd0;
    lo = 2'd0;
    act = 1'b0;
    for (int r = 0; r < 2; r++) begin
      sum[r] = 18'h00000;
      for (int i = 0; i < 4; i++)
        if (used[i] && in_r2[i] == r[0])
          sum[r] = sum[r] + {{2{avg_reg[i][15]}}, avg_reg[i]};
    end
    rd_sum = sum[rd_rail];
    avg_next = avg_reg;
    state_next = state_reg;
    st_next = st_reg;
    rail_next = rail_reg;
    light_next = light_reg;
    bal_next = bal_adj_reg;
    flags_next = flags_reg;
    adc_start_next = 1'b0;
    adc_chan_next = adc_chan_reg;
    tmr_next = (tmr_reg == 16'h0000) ? 16'(SLOT_CYC - 1) :
               tmr_reg - 16'h0001;
    unique case (state_reg)
      SM_IDLE: begin
        if (tmr_reg == 16'h0000) begin
          // alternate rails when rail two has stages, else rail one every slot
          rail_next = (cfg.n_r2 != 2'd0) ? ~rail_reg : 1'b0;
          st_next = STG_1A;
          state_next = SM_SEL;
        end
      end
      SM_SEL: begin
        if (used[st_reg] && in_r2[st_reg] == rail_reg) begin
          adc_start_next = 1'b1;
          adc_chan_next = st_reg;
          state_next = SM_WAIT;
        end else if (st_reg == STG_3A) begin
          state_next = SM_EVAL;
        end else begin
          st_next = st_reg + 2'd1; // round robin skip
        end
      end
      SM_WAIT: begin
        if (adc_done) begin
          prod = 28'(adc_data * cal_gain[st_reg]);
          smp = {1'b0, prod[CAL_FRAC+14:CAL_FRAC]} +
                cal_ofs[st_reg];
          diff = $signed({smp[15], smp}) -
                 $signed({avg_reg[st_reg][15], avg_reg[st_reg]});
          stp = diff * $signed({1'b0, FILT_K});
          avg_next[st_reg] = avg_reg[st_reg] + stp[23:8];
          st_next = st_reg + 2'd1;
          state_next = (st_reg == STG_3A) ? SM_EVAL : SM_SEL;
        end
      end
      SM_EVAL: begin
        s = $signed(sum[rail_reg]);
        flags_next[rail_reg].oc_fault = s > sx(cfg.oc_fault);
        flags_next[rail_reg].oc_warn = s > sx(cfg.oc_warn);
        flags_next[rail_reg].uc_warn = s < sx(cfg.uc_warn);
        flags_next[rail_reg].uc_fault = s < sx(cfg.uc_fault);
        if (!light_reg[rail_reg] && s < sx(cfg.ll_low))
          light_next[rail_reg] = 1'b1;
        else if (light_reg[rail_reg] && s > sx(cfg.ll_high))
          light_next[rail_reg] = 1'b0;
        // find highest and lowest active stage of this rail
        for (int i = 0; i < 4; i++) begin
          if (used[i] && in_r2[i] == rail_reg &&
              {1'b0, idx[i]} < n_act[rail_reg]) begin
            if (!act ||
                $signed(avg_reg[i]) > $signed(avg_reg[hi]))
              hi = 2'(i);
            if (!act ||
                $signed(avg_reg[i]) < $signed(avg_reg[lo]))
              lo = 2'(i);
            act = 1'b1;
          end
        end
        // equal and opposite step, both kept above zero
        if (n_act[rail_reg] > 3'd1 && hi != lo &&
            bal_adj_reg[hi] > BAL_STEP &&
            bal_adj_reg[lo] < BAL_MAX) begin
          bal_next[hi] = bal_adj_reg[hi] - BAL_STEP;
          bal_next[lo] = bal_adj_reg[lo] + BAL_STEP;
        end
        state_next = SM_IDLE;
      end
    endcase
    if (!cfg.shed_en)
      light_next = 2'b00; // shedding off
    for (int i = 0; i < 4; i++)
      stage_en_next[i] = used[i] &&
                         {1'b0, idx[i]} < n_act[in_r2[i]];
    // bank two while light, normal set restored on exit
    coef_light_next = light_next & {2{cfg.light_coef_en}};
    for (int k = 0; k < 3; k++) begin
      cmp_en_next[k] = trip_level[k] != 6'h00;
      fast_trip_next[k] = cmp_en_next[k] && pin_s2_reg[k+1];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avg_reg <= '0;
      state_reg <= SM_IDLE;
      tmr_reg <= 16'h0000;
      st_reg <= 2'd0;
      rail_reg <= 1'b1;
      light_reg <= 2'b00;
      bal_adj_reg <= {4{BAL_INIT}};
      flags_reg <= '0;
      adc_start_reg <= 1'b0;
      adc_chan_reg <= 2'd0;
      stage_en_reg <= 4'h0;
      coef_light_reg <= 2'b00;
      cmp_en_reg <= 3'h0;
      fast_trip_reg <= 3'h0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 18'h00000;
    end else if (ce) begin
      avg_reg <= avg_next;
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      st_reg <= st_next;
      rail_reg <= rail_next;
      light_reg <= light_next;
      bal_adj_reg <= bal_next;
      flags_reg <= flags_next;
      adc_start_reg <= adc_start_next;
      adc_chan_reg <= adc_chan_next;
      stage_en_reg <= stage_en_next;
      coef_light_reg <= coef_light_next;
      cmp_en_reg <= cmp_en_next;
      fast_trip_reg <= fast_trip_next;
      rd_valid_reg <= rd_req;
      rd_data_reg <= rd_req ? rd_sum : rd_data_reg;
    end
  end
  slot_start_a: assert property (ce && state_reg == SM_IDLE &&
    tmr_reg == 16'h0000 |=> state_reg == SM_SEL)
    else $error("slot did not start sampling");
  adc_pulse_a: assert property (adc_start_reg |->
    state_reg == SM_WAIT && adc_chan_reg == st_reg)
    else $error("adc start out of sequence");
  shed_enter_a: assert property (ce && state_reg == SM_EVAL &&
    cfg.shed_en && !light_reg[rail_reg] &&
    $signed(sum[rail_reg]) < sx(cfg.ll_low) |=> light_reg[$past(rail_reg)])
    else $error("light load not entered");
  restore_a: assert property (ce && state_reg == SM_EVAL &&
    light_reg[rail_reg] && $signed(sum[rail_reg]) > sx(cfg.ll_high)
    |=> !light_reg[$past(rail_reg)] ##1 !coef_light_reg[$past(rail_reg, 2)])
    else $error("normal load not restored");
  fast_off_a: assert property (ce && trip_level[0] == 6'h00 |=>
    !fast_trip_reg[0] && !cmp_en_reg[0])
    else $error("zero level comparator active");
  bal_pos_a: assert property (bal_adj_reg[0] != 12'h000 &&
    bal_adj_reg[1] != 12'h000 && bal_adj_reg[2] != 12'h000 &&
    bal_adj_reg[3] != 12'h000)
    else $error("balance value reached zero");
  read_sum_a: assert property (ce && rd_req |=>
    rd_valid_reg && rd_data_reg == $past(rd_sum))
    else $error("read did not return rail sum");
endmodule

//--- rscm_sync_src.sv
// model of a second controller that sources the sync pin
`timescale 1ns/100ps
module rscm_sync_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] gap,
  output logic sync_pin
);
  logic [7:0] cnt_reg; // cycles since the last pulse began
  // period counter, parked at zero while the source is idle
  always_ff @(posedge clk) begin
    if (!go) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg >= gap - 8'h01) begin
      cnt_reg <= 8'h00; // source period shorter than the follower
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // two-cycle high pulse per period, driven low in between
  assign sync_pin = go && (cnt_reg < 8'h02);
endmodule

//--- test_rail_sync_current_manager.sv
// self-checking bench for the rail sync and current manager
`timescale 1ns/100ps
module test_rail_sync_current_manager;
  import rscm_pkg::*;
  localparam int SLOT = 80; // short slot for simulation
  logic clk, rst, ce, sync_in, warm_restart, sync_wr, adc_done;
  logic rd_req, rd_rail, go;
  logic [7:0] gap;
  rscm_cfg_t cfg;
  logic [15:0] sync_wdata;
  logic [3:0][15:0] cal_gain, cal_ofs;
  logic [2:0][5:0] trip_level;
  logic [2:0] fast_cmp_hit;
  logic [11:0] adc_data;
  logic [15:0] sync_word_reg;
  logic sync_out_reg, phase_offset_en_reg, adc_start_reg, rd_valid_reg;
  logic [3:0][15:0] ramp_cnt_reg;
  logic [3:0] ramp_start_reg, stage_en_reg;
  logic [1:0] coef_light_reg, adc_chan_reg;
  logic [3:0][11:0] bal_adj_reg;
  logic [2:0] cmp_en_reg, fast_trip_reg;
  rscm_flags_t [1:0] flags_reg;
  logic [17:0] rd_data_reg;
  int miscompares = 0, samples_checked = 0, slots = 0, i, k, n, m;
  int unsigned seed = 10; // xorshift state
  logic [15:0] avg_m [4] = '{default: 16'h0000}; // expected stage averages
  logic [1:0] ch, exp_ch = 2'h0;
  logic [11:0] d;
  logic [15:0] mx, bs;
  logic chk_order = 1'b0, ok;
  logic [7:0] sels [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hff};
  logic signed [17:0] s;
  rscm_top #(.SLOT_CYC(SLOT)) i_dut (.clk, .rst, .ce, .sync_in,
    .warm_restart, .cfg, .sync_wr, .sync_wdata, .cal_gain, .cal_ofs,
    .trip_level, .fast_cmp_hit, .adc_done, .adc_data, .rd_req, .rd_rail,
    .sync_word_reg, .sync_out_reg, .ramp_cnt_reg, .ramp_start_reg,
    .phase_offset_en_reg, .stage_en_reg, .coef_light_reg, .bal_adj_reg,
    .adc_start_reg, .adc_chan_reg, .cmp_en_reg, .fast_trip_reg,
    .flags_reg, .rd_valid_reg, .rd_data_reg);
  rscm_sync_src i_src (.clk, .go, .gap, .sync_pin(sync_in));
  // repeatable random source
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one calibrated sample folded into a smoothed average
  function automatic logic [15:0] next_avg(logic [15:0] a, logic [11:0] v,
    logic [15:0] g, logic [15:0] o);
    logic [27:0] p;
    logic [15:0] smp;
    int df;
    p = v * g;
    smp = {1'b0, p[26:12]} + o;
    df = $signed(smp) - $signed(a);
    return a + 16'((df * int'(FILT_K)) >>> 8);
  endfunction
  // expected rail sum over all four stages
  function automatic logic signed [17:0] sum_f();
    logic signed [17:0] t;
    t = '0;
    for (int j = 0; j < 4; j++) t = t + {{2{avg_m[j][15]}}, avg_m[j]};
    return t;
  endfunction
  task automatic check(input logic [17:0] seen, exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic hang;
    miscompares++;
    $display("MISMATCH t=%0t wait ran out", $time);
    give_verdict();
  endtask
  // wait for a period start of the first stage
  task automatic wait_rs0;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      #1;
      if (ramp_start_reg[0] === 1'b1) break;
    end
    if (k == 300) hang();
  endtask
  // wait for the next completed slot of conversions
  task automatic wait_slot;
    n = slots;
    for (k = 0; k < 600 && slots == n; k++) @(posedge clk);
    if (slots == n) hang();
  endtask
  task automatic wr_sync(input logic [15:0] w);
    @(posedge clk);
    sync_wr <= 1'b1;
    sync_wdata <= w;
    @(posedge clk);
    sync_wr <= 1'b0;
    #1;
    check(sync_word_reg, w, "routing word");
  endtask
  task automatic pulse_restart;
    @(posedge clk);
    warm_restart <= 1'b1;
    @(posedge clk);
    warm_restart <= 1'b0;
  endtask
  // clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // conversion responder, tracks expected averages
  initial begin
    forever begin
      @(posedge clk);
      if (adc_start_reg === 1'b1) begin
        ch = adc_chan_reg;
        if (chk_order) check(ch, exp_ch, "channel order");
        exp_ch = ch + 2'h1;
        d = 12'(xs());
        repeat (1 + xs() % 3) @(posedge clk);
        adc_done <= 1'b1;
        adc_data <= d;
        avg_m[ch] = next_avg(avg_m[ch], d, cal_gain[ch],
                             cal_ofs[ch]);
        if (ch == 2'h3) slots++;
        @(posedge clk);
        adc_done <= 1'b0;
      end
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {warm_restart, sync_wr, adc_done, rd_req, rd_rail, go} = '0;
    {sync_wdata, adc_data, trip_level, fast_cmp_hit} = '0;
    gap = 8'h19;
    cfg = '0;
    cfg.n_r1 = 3'h1;
    cfg.n_r2 = 2'h1;
    cfg.per1 = 16'h001a;
    cfg.per2 = 16'h001a;
    cfg.oc_fault = 16'h2000;
    cfg.oc_warn = 16'h1800;
    cfg.uc_warn = 16'h0800;
    cfg.uc_fault = 16'h0400;
    for (i = 0; i < 4; i++) begin
      cal_gain[i] = 16'h0800 + 16'(xs() % 4096);
      cal_ofs[i] = 16'(xs() % 128) - 16'h0040;
    end
    repeat (20) @(posedge clk);
    check(sync_word_reg, 16'hff00, "routing word reset");
    check(phase_offset_en_reg, 1'b1, "spread reset");
    check(bal_adj_reg[2], 12'h800, "balance reset");
    rst <= 1'b0;
    wait_rs0();
    check(ramp_cnt_reg[2], 16'd20, "rail spread");
    $display("test rail spread done");
    cfg.n_r1 <= 3'h4;
    cfg.n_r2 <= 2'h0;
    cfg.per1 <= 16'h0028;
    pulse_restart();
    wait_rs0();
    for (i = 1; i < 4; i++)
      check(ramp_cnt_reg[i], 16'(40 - 10 * i), "stage spread");
    $display("test stage spread done");
    foreach (sels[j]) begin
      wr_sync({sels[j], 8'h00});
      n = 0;
      repeat (80) begin
        @(posedge clk);
        #1;
        n += sync_out_reg;
      end
      check(n, (sels[j] <= 8'h03) ? 2 : 0, "sync out count");
    end
    $display("test sync out done");
    for (m = 0; m < 3; m++) begin
      wr_sync({8'hff, 8'(m != 0)});
      gap <= (m == 2) ? 8'h03 : 8'h19; // last pass: sync every 3 cycles
      go <= 1'b1;
      mx = 16'h0000;
      for (i = 0; i < 250; i++) begin
        @(posedge clk);
        #1;
        if (i >= 60 && ramp_cnt_reg[0] > mx) mx = ramp_cnt_reg[0];
      end
      ok = (m == 0) ? (mx == 16'd39) : (mx < ((m == 1) ? 16'd30 : 16'd3));
      check(ok, 1'b1, "ramp lock");
      check(phase_offset_en_reg, m == 0, "spread after sync");
      @(posedge clk);
      go <= 1'b0;
    end
    pulse_restart();
    repeat (2) @(posedge clk);
    #1;
    check(phase_offset_en_reg, 1'b1, "spread restored");
    $display("test sync in done");
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      trip_level[i] <= (i == 1) ? 6'h00 : 6'(xs()) | 6'h01;
      fast_cmp_hit <= 3'b111;
      repeat (4) @(posedge clk);
      #1;
      check(cmp_en_reg[i], i != 1, "comparator enable");
      check(fast_trip_reg[i], i != 1, "comparator trip");
    end
    $display("test comparator done");
    wr_sync(16'hff00);
    wait_slot();
    chk_order = 1'b1;
    repeat (6) begin
      wait_slot();
      repeat (8) @(posedge clk);
      @(posedge clk);
      rd_req <= 1'b1;
      @(posedge clk);
      rd_req <= 1'b0;
      #1;
      s = sum_f();
      check(rd_valid_reg, 1'b1, "read valid");
      check(rd_data_reg, s, "rail sum");
      check(flags_reg[0], {s > $signed(cfg.oc_fault), s > $signed(cfg.oc_warn),
        s < $signed(cfg.uc_warn), s < $signed(cfg.uc_fault)}, "flags");
      bs = 16'h0000;
      ok = 1'b1;
      for (i = 0; i < 4; i++) begin
        bs += bal_adj_reg[i];
        ok &= (bal_adj_reg[i] != 12'h000);
      end
      check(bs, 16'h2000, "balance total");
      check(ok, 1'b1, "balance positive");
      // second rail holds no stages in this layout
      @(posedge clk);
      rd_req <= 1'b1;
      rd_rail <= 1'b1;
      @(posedge clk);
      rd_req <= 1'b0;
      rd_rail <= 1'b0;
      #1;
      check(rd_data_reg, 18'h00000, "empty rail sum");
    end
    $display("test current monitor done");
    chk_order = 1'b0;
    @(posedge clk);
    cfg.shed_en <= 1'b1;
    cfg.shed_n <= 2'h2;
    cfg.light_coef_en <= 1'b1;
    cfg.ll_low <= 16'h7fff;
    cfg.ll_high <= 16'h7fff;
    repeat (3 * SLOT) @(posedge clk);
    #1;
    check(stage_en_reg, 4'h3, "shed stages");
    check(coef_light_reg[0], 1'b1, "light bank");
    @(posedge clk);
    cfg.ll_low <= 16'h8000;
    cfg.ll_high <= 16'h8000;
    repeat (3 * SLOT) @(posedge clk);
    #1;
    check(stage_en_reg, 4'hf, "restore stages");
    check(coef_light_reg[0], 1'b0, "normal bank");
    $display("test shedding done");
    give_verdict();
  end
endmodule
